// file: cdt_pkg.sv
// Constants, register map and carrier types of the cell-based display timing block.
package cdt_pkg;
	// ----------------------------------------------------------------
	// Host register offsets (byte offsets inside the 16-byte window)
	// ----------------------------------------------------------------
	localparam logic [3:0] OFS_X = 4'h0;
	localparam logic [3:0] OFS_Y = 4'h2;
	localparam logic [3:0] OFS_DATA = 4'h4;
	localparam logic [3:0] OFS_STAT_CTL1 = 4'h6;
	localparam logic [3:0] OFS_PARAM_SEL = 4'hc;
	localparam logic [3:0] OFS_PARAM_DATA = 4'he;
	// ----------------------------------------------------------------
	// Indirect timing parameter indices
	// ----------------------------------------------------------------
	localparam logic [4:0] IDX_HTOTAL = 5'h00;
	localparam logic [4:0] IDX_HDISP = 5'h01;
	localparam logic [4:0] IDX_HSYNCPOS = 5'h02;
	localparam logic [4:0] IDX_SYNCW = 5'h03;
	localparam logic [4:0] IDX_VTOTAL = 5'h04;
	localparam logic [4:0] IDX_VADJ = 5'h05;
	localparam logic [4:0] IDX_VDISP = 5'h06;
	localparam logic [4:0] IDX_VSYNCPOS = 5'h07;
	localparam logic [4:0] IDX_SCANMODE = 5'h08;
	localparam logic [4:0] IDX_LINESROW = 5'h09;
	localparam logic [4:0] IDX_STARTHI = 5'h0c;
	localparam logic [4:0] IDX_STARTLO = 5'h0d;
	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int CTL1_CLIP_BIT = 1;
	localparam int CTL1_XZOOM_LSB = 11;
	localparam int CTL1_YZOOM_LSB = 14;
	localparam int STAT_BUSY_BIT = 15;
	localparam int SYNCW_H_LSB = 0;
	localparam int SYNCW_V_LSB = 4;
	localparam int CLIP_LSB = 9;
	localparam int COORD_W = 12;
	localparam int CELL_LAST = 7;
	localparam logic [15:0] REG16_RST = 16'h0000;
	localparam logic [7:0] REG8_RST = 8'h00;
	// ----------------------------------------------------------------
	// Carrier types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic wr;
		logic rd;
		logic [3:0] addr;
		logic [15:0] wdata;
	} cdt_host_req_t;
	typedef struct packed {
		logic req;
		logic we;
		logic [17:0] addr;
		logic [3:0] wdata;
	} cdt_mem_req_t;
	typedef struct packed {
		logic dotEn;
		logic hSync;
		logic vSync;
		logic dispEn;
		logic [13:0] cellAddr;
		logic [2:0] pixCol;
		logic [2:0] pixRow;
	} cdt_video_t;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_MEM = 2'b01,
		ST_WAIT = 2'b11
	} cdt_acc_state_t;
endpackage

// file: cdt_display_timing.sv
// Cell-based raster timing generator with host pixel access port.
`timescale 1ns/1ns
// Summary of operation
// RULE1 - Dot enable rate is the master clock divided by the horizontal zoom factor.
// RULE2 - Cell enable fires once every eight dot enables.
// RULE3 - Counters work on 8x8 cells; pixel logic steps pixels inside a cell.
// RULE4 - Software loads horizontal total as line period in cells minus one.
// RULE5 - Active pixels shown only for horizontal displayed cells after line start.
// RULE6 - Software sets horizontal sync position midway in the blank interval.
// RULE7 - A cell row lasts vertical zoom times 8 lines; vertical total is rows minus one.
// RULE8 - Software derives vertical values from 33.334ms or 40.000ms frame periods.
// RULE9 - After the last cell row, vertical adjust extra lines precede the next frame.
// RULE10 - Vertical displayed gives the number of visible cell rows.
// RULE11 - Software sets vertical sync position midway in the blank rows.
// RULE12 - Lines per cell row is 8 times zoom minus one; rows repeat per zoom.
// RULE13 - Horizontal sync width in cells comes from sync width bits 0-3.
// RULE14 - Vertical sync width in lines comes from sync width bits 4-7.
// RULE15 - Host uses full word transfers only, never byte read-modify-write.
// RULE16 - Software writes every register once after power-up before initialising.
// RULE17 - X coordinate register holds a 12 bit pixel column address.
// RULE18 - With clipping on, X bits 9-11 nonzero block the memory access.
// RULE19 - Y holds 12 bits; with clipping on, bits 9-11 nonzero block access.
// RULE20 - Pixel data uses a strapped four-bit nibble of the data register.
// RULE21 - Data bits outside the pixel nibble are ignored on write, read zero.
// RULE22 - Status bit 15 reads one while preset or frame grab is busy.
// RULE23 - Clipping blocks nothing unless the clipping enable bit is one.
// RULE24 - Horizontal zoom field sits in control register bits 11-13.
// RULE25 - Vertical zoom field sits in control register bits 14-15.
// RULE26 - Syncs assert at the programmed position and last the programmed width.
// RULE27 - Each frame's refresh address starts at the display start cell.
module cdt_display_timing
	import cdt_pkg::*;
(
	input wire logic mclk, // 250 MHz master clock
	input wire logic sys_rst, // Asynchronous reset, active high
	input wire cdt_host_req_t hostReq, // One-cycle host read or write strobe
	output logic [15:0] hostRdata, // Read data, valid with hostAck
	output logic hostAck, // One-cycle answer to a taken request
	input wire logic [1:0] portNibbleStrap, // Pixel nibble position strap
	input wire logic presetGrabBusy, // Preset or frame grab in progress
	output cdt_mem_req_t memReq, // Display memory access request
	input wire logic [3:0] memRdata, // Memory data, one cycle after a read
	output cdt_video_t video // Raster timing outputs
);
	// ----------------------------------------------------------------
	// Host-visible registers
	// ----------------------------------------------------------------
	logic [15:0] xCoord_ff;
	logic [15:0] yCoord_ff;
	logic [15:0] ctl1_ff;
	logic [4:0] paramSel_ff;
	logic [7:0] hTotal_ff;
	logic [7:0] hDisp_ff;
	logic [7:0] hSyncPos_ff;
	logic [7:0] syncW_ff;
	logic [7:0] vTotal_ff;
	logic [7:0] vAdj_ff;
	logic [7:0] vDisp_ff;
	logic [7:0] vSyncPos_ff;
	logic [7:0] scanMode_ff;
	logic [7:0] linesRow_ff;
	logic [7:0] startHi_ff;
	logic [7:0] startLo_ff;
	logic [1:0] portSel_ff;
	logic strapTaken_ff;
	logic busy_ff;
	cdt_acc_state_t accState_ff;
	logic [15:0] hostRdata_ff;
	logic hostAck_ff;
	cdt_mem_req_t memReq_ff;

	logic reqTaken;
	logic clipped;
	logic [7:0] paramRead;
	logic [15:0] nibbleOut;
	logic [3:0] nibbleIn;

	assign reqTaken = (hostReq.wr || hostReq.rd) && (accState_ff == ST_IDLE);

	// Clipping only matters while enabled.
	assign clipped = ctl1_ff[CTL1_CLIP_BIT]
		&& ((|xCoord_ff[COORD_W-1:CLIP_LSB]) || (|yCoord_ff[COORD_W-1:CLIP_LSB])); // [RULE18] [RULE19] [RULE23]

	// Only the strapped nibble reaches memory; the other data bits read as zero.
	assign nibbleOut = {12'h000, memRdata} << {portSel_ff, 2'b00}; // [RULE20] [RULE21]
	assign nibbleIn = 4'(hostReq.wdata >> {portSel_ff, 2'b00}); // [RULE20]

	always_comb
	begin
		unique case (paramSel_ff)
			IDX_HTOTAL: paramRead = hTotal_ff;
			IDX_HDISP: paramRead = hDisp_ff;
			IDX_HSYNCPOS: paramRead = hSyncPos_ff;
			IDX_SYNCW: paramRead = syncW_ff;
			IDX_VTOTAL: paramRead = vTotal_ff;
			IDX_VADJ: paramRead = vAdj_ff;
			IDX_VDISP: paramRead = vDisp_ff;
			IDX_VSYNCPOS: paramRead = vSyncPos_ff;
			IDX_SCANMODE: paramRead = scanMode_ff;
			IDX_LINESROW: paramRead = linesRow_ff;
			IDX_STARTHI: paramRead = startHi_ff;
			IDX_STARTLO: paramRead = startLo_ff;
			default: paramRead = REG8_RST;
		endcase
	end

	// ----------------------------------------------------------------
	// Strap capture after reset release
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			portSel_ff <= 2'h0;
			strapTaken_ff <= 1'b0;
		end
		else if (!strapTaken_ff)
		begin
			portSel_ff <= portNibbleStrap; // [RULE20]
			strapTaken_ff <= 1'b1;
		end
	end

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
			busy_ff <= 1'b0;
		else
			busy_ff <= presetGrabBusy; // [RULE22]
	end

	// ----------------------------------------------------------------
	// Register writes
	// ----------------------------------------------------------------
	// Every write replaces the whole word; there are no byte lanes.
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			xCoord_ff <= REG16_RST;
			yCoord_ff <= REG16_RST;
			ctl1_ff <= REG16_RST;
			paramSel_ff <= 5'h00;
		end
		else if (reqTaken && hostReq.wr)
		begin
			unique case (hostReq.addr)
				OFS_X: xCoord_ff <= {4'h0, hostReq.wdata[COORD_W-1:0]}; // [RULE17] [RULE15]
				OFS_Y: yCoord_ff <= {4'h0, hostReq.wdata[COORD_W-1:0]}; // [RULE19]
				OFS_STAT_CTL1: ctl1_ff <= hostReq.wdata; // [RULE24] [RULE25]
				OFS_PARAM_SEL: paramSel_ff <= hostReq.wdata[4:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			hTotal_ff <= REG8_RST;
			hDisp_ff <= REG8_RST;
			hSyncPos_ff <= REG8_RST;
			syncW_ff <= REG8_RST;
			vTotal_ff <= REG8_RST;
			vAdj_ff <= REG8_RST;
			vDisp_ff <= REG8_RST;
			vSyncPos_ff <= REG8_RST;
			scanMode_ff <= REG8_RST;
			linesRow_ff <= REG8_RST;
			startHi_ff <= REG8_RST;
			startLo_ff <= REG8_RST;
		end
		else if (reqTaken && hostReq.wr && hostReq.addr == OFS_PARAM_DATA)
		begin
			unique case (paramSel_ff)
				IDX_HTOTAL: hTotal_ff <= hostReq.wdata[7:0];
				IDX_HDISP: hDisp_ff <= hostReq.wdata[7:0];
				IDX_HSYNCPOS: hSyncPos_ff <= hostReq.wdata[7:0];
				IDX_SYNCW: syncW_ff <= hostReq.wdata[7:0];
				IDX_VTOTAL: vTotal_ff <= hostReq.wdata[7:0];
				IDX_VADJ: vAdj_ff <= hostReq.wdata[7:0];
				IDX_VDISP: vDisp_ff <= hostReq.wdata[7:0];
				IDX_VSYNCPOS: vSyncPos_ff <= hostReq.wdata[7:0];
				IDX_SCANMODE: scanMode_ff <= hostReq.wdata[7:0];
				IDX_LINESROW: linesRow_ff <= hostReq.wdata[7:0];
				IDX_STARTHI: startHi_ff <= hostReq.wdata[7:0];
				IDX_STARTLO: startLo_ff <= hostReq.wdata[7:0];
				default: ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Host access sequencing and pixel port
	// ----------------------------------------------------------------
	// A pixel read waits for the memory; other requests answer next cycle.
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			accState_ff <= ST_IDLE;
			hostRdata_ff <= REG16_RST;
			hostAck_ff <= 1'b0;
			memReq_ff <= '0;
		end
		else
		begin
			hostAck_ff <= 1'b0;
			memReq_ff.req <= 1'b0;
			memReq_ff.we <= 1'b0;
			unique case (accState_ff)
				ST_IDLE:
				begin
					if (reqTaken && hostReq.rd && hostReq.addr == OFS_DATA)
					begin
						memReq_ff.req <= !clipped; // [RULE18] [RULE19]
						memReq_ff.addr <= {yCoord_ff[8:0], xCoord_ff[8:0]};
						accState_ff <= ST_MEM;
					end
					else if (reqTaken)
					begin
						hostAck_ff <= 1'b1;
						hostRdata_ff <= REG16_RST;
						if (hostReq.wr && hostReq.addr == OFS_DATA)
						begin
							memReq_ff.req <= !clipped; // [RULE23]
							memReq_ff.we <= 1'b1;
							memReq_ff.addr <= {yCoord_ff[8:0], xCoord_ff[8:0]};
							memReq_ff.wdata <= nibbleIn; // [RULE21]
						end
						else if (hostReq.rd && hostReq.addr == OFS_STAT_CTL1)
							hostRdata_ff[STAT_BUSY_BIT] <= busy_ff; // [RULE22]
						else if (hostReq.rd && hostReq.addr == OFS_PARAM_DATA)
							hostRdata_ff <= {8'h00, paramRead};
					end
				end
				ST_MEM:
					accState_ff <= ST_WAIT;
				ST_WAIT:
				begin
					accState_ff <= ST_IDLE;
					hostAck_ff <= 1'b1;
					hostRdata_ff <= clipped ? REG16_RST : nibbleOut; // [RULE21]
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Dot and cell enables
	// ----------------------------------------------------------------
	logic [2:0] dotDiv_ff;
	logic [2:0] pixCol_ff;
	logic dotEn;
	logic cellEn;
	logic [1:0] yShift;

	// Zoom field 0..7 means divide by 1..8, so compare against the field.
	assign dotEn = (dotDiv_ff >= ctl1_ff[CTL1_XZOOM_LSB +: 3]); // [RULE1] [RULE24]
	assign cellEn = dotEn && (pixCol_ff == 3'(CELL_LAST)); // [RULE2] [RULE3]
	assign yShift = ctl1_ff[CTL1_YZOOM_LSB +: 2] == 2'd3 ? 2'd2 : ctl1_ff[CTL1_YZOOM_LSB +: 2]; // [RULE25]

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			dotDiv_ff <= 3'h0;
			pixCol_ff <= 3'h0;
		end
		else
		begin
			dotDiv_ff <= dotEn ? 3'h0 : dotDiv_ff + 3'h1; // [RULE1]
			if (dotEn)
				pixCol_ff <= pixCol_ff + 3'h1; // [RULE3]
		end
	end

	// ----------------------------------------------------------------
	// Horizontal and vertical counters
	// ----------------------------------------------------------------
	logic [7:0] hCnt_ff;
	logic [7:0] rowCnt_ff;
	logic [4:0] scanLn_ff;
	logic [7:0] adjCnt_ff;
	logic inAdj_ff;
	logic [13:0] rowBase_ff;
	logic [3:0] vLeft_ff;
	logic lineEnd;
	logic rowEnd;
	logic frameEnd;
	logic [7:0] nxtRowCnt;

	assign lineEnd = cellEn && (hCnt_ff == hTotal_ff); // [RULE4]
	assign rowEnd = !inAdj_ff && (scanLn_ff == linesRow_ff[4:0]); // [RULE7] [RULE12]
	assign frameEnd = inAdj_ff ? (adjCnt_ff + 8'h01 >= vAdj_ff)
		: (rowEnd && rowCnt_ff == vTotal_ff && vAdj_ff == REG8_RST); // [RULE9]
	assign nxtRowCnt = rowCnt_ff + 8'h01;

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
			hCnt_ff <= 8'h00;
		else if (cellEn)
			hCnt_ff <= lineEnd ? 8'h00 : hCnt_ff + 8'h01; // [RULE3]
	end

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			rowCnt_ff <= 8'h00;
			scanLn_ff <= 5'h00;
			adjCnt_ff <= 8'h00;
			inAdj_ff <= 1'b0;
			rowBase_ff <= 14'h0000;
		end
		else if (lineEnd)
		begin
			if (frameEnd)
			begin
				rowCnt_ff <= 8'h00;
				scanLn_ff <= 5'h00;
				inAdj_ff <= 1'b0;
				rowBase_ff <= {startHi_ff[5:0], startLo_ff}; // [RULE27]
			end
			else if (inAdj_ff)
				adjCnt_ff <= adjCnt_ff + 8'h01; // [RULE9]
			else if (rowEnd)
			begin
				scanLn_ff <= 5'h00;
				if (rowCnt_ff == vTotal_ff)
				begin
					inAdj_ff <= 1'b1; // [RULE9]
					adjCnt_ff <= 8'h00;
				end
				else
				begin
					rowCnt_ff <= nxtRowCnt; // [RULE7]
					rowBase_ff <= rowBase_ff + {6'h00, hDisp_ff};
				end
			end
			else
				scanLn_ff <= scanLn_ff + 5'h01;
		end
	end

	// Vertical sync counts whole lines from the first line of its row.
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
			vLeft_ff <= 4'h0;
		else if (lineEnd)
		begin
			if (rowEnd && !frameEnd && rowCnt_ff != vTotal_ff && nxtRowCnt == vSyncPos_ff)
				vLeft_ff <= syncW_ff[SYNCW_V_LSB +: 4]; // [RULE14] [RULE26]
			else if (frameEnd && vSyncPos_ff == REG8_RST)
				vLeft_ff <= syncW_ff[SYNCW_V_LSB +: 4]; // [RULE26]
			else if (vLeft_ff != 4'h0)
				vLeft_ff <= vLeft_ff - 4'h1;
		end
	end

	// ----------------------------------------------------------------
	// Registered video outputs
	// ----------------------------------------------------------------
	logic [7:0] hOff;
	logic hSyncNow;
	logic [4:0] pixRowFull;
	cdt_video_t video_ff;

	assign hOff = hCnt_ff - hSyncPos_ff;
	assign hSyncNow = (hCnt_ff >= hSyncPos_ff)
		&& (hOff < {4'h0, syncW_ff[SYNCW_H_LSB +: 4]}); // [RULE13] [RULE26]
	assign pixRowFull = scanLn_ff >> yShift; // [RULE12]

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
			video_ff <= '0;
		else
		begin
			video_ff.dotEn <= dotEn;
			video_ff.hSync <= hSyncNow;
			video_ff.vSync <= vLeft_ff != 4'h0;
			video_ff.dispEn <= (hCnt_ff < hDisp_ff) && (rowCnt_ff < vDisp_ff) && !inAdj_ff; // [RULE5] [RULE10]
			video_ff.cellAddr <= rowBase_ff + {6'h00, hCnt_ff}; // [RULE27]
			video_ff.pixCol <= pixCol_ff;
			video_ff.pixRow <= pixRowFull[2:0];
		end
	end

	assign hostRdata = hostRdata_ff;
	assign hostAck = hostAck_ff;
	assign memReq = memReq_ff;
	assign video = video_ff;
endmodule // cdt_display_timing

// file: cdt_display_timing_props.sv
// Concurrent checks on the host and memory ports of the display timing block.
`timescale 1ns/1ns
module cdt_display_timing_props
	import cdt_pkg::*;
(
	input wire logic mclk, // Master clock
	input wire logic sys_rst, // Reset, active high
	input wire cdt_host_req_t hostReq, // Host strobes
	input wire logic [15:0] hostRdata, // Read data
	input wire logic hostAck, // Answer pulse
	input wire logic [1:0] portNibbleStrap, // Nibble strap
	input wire logic presetGrabBusy, // Busy level
	input wire cdt_mem_req_t memReq, // Memory request
	input wire logic [3:0] memRdata, // Memory data
	input wire cdt_video_t video // Raster outputs
);
	// Shadow copies of the coordinates, since the real ones are write-only.
	logic [11:0] xPos_ff;
	logic [11:0] yPos_ff;
	logic clipOn_ff;
	logic [15:0] nibMask;
	logic [4:0] sh;
	logic dataWr;
	logic dataRd;
	logic blockAcc;
	assign sh = {1'b0, portNibbleStrap, 2'b00};
	assign nibMask = 16'h000f << sh;
	assign dataWr = hostReq.wr && hostReq.addr == OFS_DATA;
	assign dataRd = hostReq.rd && hostReq.addr == OFS_DATA;
	assign blockAcc = clipOn_ff && (xPos_ff[11:9] != 3'h0 || yPos_ff[11:9] != 3'h0);
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			xPos_ff <= 12'h000;
			yPos_ff <= 12'h000;
			clipOn_ff <= 1'b0;
		end
		else if (hostReq.wr)
		begin
			if (hostReq.addr == OFS_X)
				xPos_ff <= hostReq.wdata[11:0];
			if (hostReq.addr == OFS_Y)
				yPos_ff <= hostReq.wdata[11:0];
			if (hostReq.addr == OFS_STAT_CTL1)
				clipOn_ff <= hostReq.wdata[CTL1_CLIP_BIT];
		end
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	a_read_latency: assert property (memReq.req && !memReq.we |=> !hostAck ##1 hostAck)
		else $error("data read answer not three cycles after take");
	a_read_nibble: assert property (memReq.req && !memReq.we |=> ##1
		((hostRdata & nibMask) == ({12'h000, $past(memRdata)} << sh)))
		else $error("read nibble not in strapped position");
	a_read_upper: assert property (dataRd |-> ##[1:3] (hostAck && (hostRdata & ~nibMask) == 16'h0000))
		else $error("unused data bits not zero on read");
	a_write_nibble: assert property (dataWr && !blockAcc |=> memReq.req && memReq.we &&
		memReq.wdata == 4'(($past(hostReq.wdata) & nibMask) >> sh))
		else $error("write nibble not taken from strapped position");
	a_clip_x: assert property (dataWr && clipOn_ff && xPos_ff[11:9] != 3'h0 |=> !memReq.req)
		else $error("memory access not blocked by x clip");
	a_clip_y: assert property ((dataWr || dataRd) && clipOn_ff && yPos_ff[11:9] != 3'h0
		|=> !memReq.req)
		else $error("memory access not blocked by y clip");
	a_clip_read_zero: assert property (dataRd && blockAcc |-> ##3
		(hostAck && hostRdata == 16'h0000))
		else $error("clipped read not answered with zero");
	a_clip_off: assert property ((dataWr || dataRd) && !clipOn_ff |=> memReq.req)
		else $error("access blocked while clipping disabled");
	a_mem_addr: assert property (memReq.req |-> memReq.addr == {yPos_ff[8:0], xPos_ff[8:0]})
		else $error("memory address not formed from coordinates");
	a_status_busy: assert property (hostReq.rd && hostReq.addr == OFS_STAT_CTL1 &&
		presetGrabBusy == $past(presetGrabBusy) |=> hostAck &&
		hostRdata[STAT_BUSY_BIT] == $past(presetGrabBusy, 2))
		else $error("status busy bit does not follow busy input");
	c_data_write: cover property (dataWr ##1 memReq.req);
	c_clip_read: cover property (dataRd && blockAcc);
	c_vsync: cover property ($rose(video.vSync));
endmodule // cdt_display_timing_props
bind cdt_display_timing cdt_display_timing_props i_cdt_display_timing_props (.mclk(mclk),
	.sys_rst(sys_rst), .hostReq(hostReq), .hostRdata(hostRdata), .hostAck(hostAck),
	.portNibbleStrap(portNibbleStrap), .presetGrabBusy(presetGrabBusy), .memReq(memReq),
	.memRdata(memRdata), .video(video));

// file: cdt_mem_model.sv
// Display memory model with one cycle read latency.
`timescale 1ns/1ns
module cdt_mem_model
	import cdt_pkg::*;
(
	input wire logic mclk, // Master clock
	input wire cdt_mem_req_t memReq, // Access request
	output logic [3:0] memRdata // Read data
);
	logic [3:0] store [logic [17:0]];
	initial memRdata = 4'h0;
	// Outside a read answer the data toggles, so stale data never passes for fresh.
	always @(posedge mclk)
	begin
		if (memReq.req && memReq.we)
			store[memReq.addr] = memReq.wdata;
		if (memReq.req && !memReq.we)
			memRdata <= store.exists(memReq.addr) ? store[memReq.addr] : 4'h9;
		else
			memRdata <= ~memRdata;
	end
endmodule // cdt_mem_model

// file: tb_top.sv
// Self-checking bench for the display timing block and its host port.
`timescale 1ns/1ns
module tb_top
	import cdt_pkg::*;
;
	logic mclk;
	logic sys_rst;
	cdt_host_req_t hostReq;
	logic [15:0] hostRdata;
	logic hostAck;
	logic presetGrabBusy;
	cdt_mem_req_t memReq;
	logic [3:0] memRdata;
	cdt_video_t video;
	logic [15:0] rd;
	int errors = 0;
	int checked = 0;
	int cyc = 0;
	cdt_display_timing i_cdt_display_timing (.mclk(mclk), .sys_rst(sys_rst), .hostReq(hostReq),
		.hostRdata(hostRdata), .hostAck(hostAck), .portNibbleStrap(2'd1),
		.presetGrabBusy(presetGrabBusy), .memReq(memReq), .memRdata(memRdata), .video(video));
	cdt_mem_model i_cdt_mem_model (.mclk(mclk), .memReq(memReq), .memRdata(memRdata));
	initial
	begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	task automatic print_verdict;
		$display("Checks %0d, mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 40000)
		begin
			errors++;
			print_verdict;
		end
	end
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp)
		begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// One-cycle strobe, then wait for the answer pulse at each falling edge.
	task automatic hostOp(input logic wr, input logic [3:0] addr, input logic [15:0] wd);
		int i;
		@(negedge mclk);
		hostReq = '{wr: wr, rd: !wr, addr: addr, wdata: wd};
		@(negedge mclk);
		hostReq = '0;
		for (i = 0; i < 6 && hostAck !== 1'b1; i++)
			@(negedge mclk);
		check("hostAck", {15'h0, hostAck}, 16'h0001);
		rd = hostRdata;
	endtask
	task automatic wrP(input int idx, input logic [7:0] val);
		hostOp(1'b1, OFS_PARAM_SEL, 16'(idx));
		hostOp(1'b1, OFS_PARAM_DATA, {8'h00, val});
	endtask
	function automatic logic sig(input int k);
		return k == 0 ? video.hSync : (k == 1 ? video.vSync : video.dispEn);
	endfunction
	// Measures high time and rise-to-rise period, and counts display cycles meanwhile.
	task automatic measure(input int k, output int hi, output int per, output int dsp);
		int n;
		hi = 0;
		per = 0;
		dsp = 0;
		for (n = 0; n < 9000 && sig(k) === 1'b1; n++)
			@(negedge mclk);
		for (n = 0; n < 9000 && sig(k) !== 1'b1; n++)
			@(negedge mclk);
		while (per < 9000 && sig(k) === 1'b1)
		begin
			hi++;
			per++;
			dsp += (video.dispEn === 1'b1);
			@(negedge mclk);
		end
		while (per < 9000 && sig(k) !== 1'b1)
		begin
			per++;
			dsp += (video.dispEn === 1'b1);
			@(negedge mclk);
		end
	endtask
	task automatic t_params;
		int i;
		for (i = 0; i < 14; i++)
			wrP(i, 8'(8'h30 + i));
		for (i = 0; i < 14; i++)
		begin
			hostOp(1'b1, OFS_PARAM_SEL, 16'(i));
			hostOp(1'b0, OFS_PARAM_DATA, 16'h0000);
			check("param", rd, (i == 10 || i == 11) ? 16'h0000 : 16'(16'h30 + i));
		end
		hostOp(1'b0, OFS_X, 16'h0000);
		check("x readback", rd, 16'h0000);
		hostOp(1'b0, 4'h8, 16'h0000);
		check("unmapped", rd, 16'h0000);
	endtask
	task automatic t_format;
		// The frame is far shorter than a monitor's so that whole frames fit the run.
		logic [7:0] fmt [14] = '{8'd9, 8'd4, 8'd6, 8'h12, 8'd2, 8'd1, 8'd1, 8'd1, 8'd0, 8'd7,
			8'd0, 8'd0, 8'd0, 8'd0};
		int i;
		int hi;
		int per;
		int dsp;
		for (i = 0; i < 14; i++)
			wrP(i, fmt[i]);
		hostOp(1'b1, OFS_STAT_CTL1, 16'h0800);
		hostOp(1'b1, OFS_STAT_CTL1, 16'h0800);
		measure(0, hi, per, dsp);
		check("hsync width", 16'(hi), 16'd32);
		check("line period", 16'(per), 16'd160);
		measure(2, hi, per, dsp);
		check("display width", 16'(hi), 16'd64);
		measure(1, hi, per, dsp);
		check("vsync width", 16'(hi), 16'd160);
		check("frame period", 16'(per), 16'd4000);
		check("display per frame", 16'(dsp), 16'd512);
	endtask
	task automatic t_pixel;
		hostOp(1'b1, OFS_X, 16'h0005);
		hostOp(1'b1, OFS_Y, 16'h0003);
		hostOp(1'b1, OFS_DATA, 16'hfff7);
		hostOp(1'b0, OFS_DATA, 16'h0000);
		check("pixel read", rd, 16'h00f0);
		hostOp(1'b1, OFS_DATA, 16'h0a5c);
		hostOp(1'b0, OFS_DATA, 16'h0000);
		check("pixel read", rd, 16'h0050);
		hostOp(1'b1, OFS_X, 16'h0205);
		hostOp(1'b1, OFS_STAT_CTL1, 16'h0802);
		hostOp(1'b1, OFS_DATA, 16'h00a0);
		hostOp(1'b0, OFS_DATA, 16'h0000);
		check("x clipped read", rd, 16'h0000);
		hostOp(1'b1, OFS_X, 16'h0005);
		hostOp(1'b1, OFS_Y, 16'h0203);
		hostOp(1'b0, OFS_DATA, 16'h0000);
		check("y clipped read", rd, 16'h0000);
		hostOp(1'b1, OFS_X, 16'h0205);
		hostOp(1'b1, OFS_STAT_CTL1, 16'h0800);
		hostOp(1'b0, OFS_DATA, 16'h0000);
		check("unclipped read", rd, 16'h0050);
	endtask
	// Waits for the next frame's first visible cell, then three lines further on.
	task automatic toLine3;
		int n;
		for (n = 0; n < 9000 && video.vSync !== 1'b1; n++)
			@(negedge mclk);
		for (n = 0; n < 9000 && video.dispEn !== 1'b1; n++)
			@(negedge mclk);
		repeat (480) @(negedge mclk);
	endtask
	task automatic t_raster;
		int n;
		wrP(13, 8'h10);
		toLine3;
		check("row start cell", {2'b00, video.cellAddr}, 16'h0010);
		check("pixel row", {13'h0000, video.pixRow}, 16'h0003);
		repeat (5) @(negedge mclk);
		check("pixel column", {13'h0000, video.pixCol}, 16'h0002);
		hostOp(1'b1, OFS_STAT_CTL1, 16'h4800);
		toLine3;
		check("zoomed pixel row", {13'h0000, video.pixRow}, 16'h0001);
		for (n = 0; n < 20 && video.dotEn !== 1'b1; n++)
			@(negedge mclk);
		@(negedge mclk);
		check("dot gap", {15'h0000, video.dotEn}, 16'h0000);
		@(negedge mclk);
		check("dot pulse", {15'h0000, video.dotEn}, 16'h0001);
	endtask
	task automatic t_status;
		presetGrabBusy = 1'b1;
		repeat (3) @(negedge mclk);
		hostOp(1'b0, OFS_STAT_CTL1, 16'h0000);
		check("busy set", rd & 16'h8000, 16'h8000);
		presetGrabBusy = 1'b0;
		repeat (3) @(negedge mclk);
		hostOp(1'b0, OFS_STAT_CTL1, 16'h0000);
		check("busy clear", rd & 16'h8000, 16'h0000);
	endtask
	initial
	begin
		sys_rst = 1'b1;
		hostReq = '0;
		presetGrabBusy = 1'b0;
		repeat (2) @(posedge mclk);
		@(negedge mclk);
		sys_rst = 1'b0;
		repeat (2) @(negedge mclk);
		t_params;
		t_format;
		t_raster;
		t_pixel;
		t_status;
		print_verdict;
	end
endmodule // tb_top
